//--- verilog/isc_pkg.sv
// Constants, addresses and check helpers of the input serialiser port
package isc_pkg;

    // ****************************************
    // Frame geometry
    // ****************************************
    localparam int          ISC_FRAME_CHK  = 24;
    localparam int          ISC_FRAME_RAW  = 16;
    localparam int          ISC_CRC_SPAN   = 19;
    localparam logic [4:0]  ISC_CRC_SEED   = 5'h07;
    localparam logic [4:0]  ISC_CRC_POLY   = 5'h15;

    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [6:0]  ISC_A_INPUT    = 7'h02;
    localparam logic [6:0]  ISC_A_FAULT_STATUS_FIRST   = 7'h04;
    localparam logic [6:0]  ISC_A_FLT_BASE = 7'h06;
    localparam logic [6:0]  ISC_A_FLT_END  = 7'h16;
    localparam logic [6:0]  ISC_A_CHAN_EN  = 7'h16;
    localparam logic [6:0]  ISC_A_F1_EN    = 7'h18;
    localparam logic [6:0]  ISC_A_F2_EN    = 7'h1a;
    localparam logic [6:0]  ISC_A_FAULT_STATUS_SECOND   = 7'h1c;

    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [7:0]  ISC_RST_F1_EN  = 8'hc0;
    localparam logic [7:0]  ISC_RST_F2_EN  = 8'h00;
    localparam logic [7:0]  ISC_RST_FLT    = 8'h08;
    localparam logic [7:0]  ISC_RST_CHAN   = 8'hff;
    localparam int          ISC_F1_CRC     = 7;
    localparam int          ISC_F1_POR     = 6;
    localparam int          ISC_F1_SUM     = 5;
    localparam int          ISC_F1_LOW     = 2;
    localparam int          ISC_F1_MISS    = 1;
    localparam int          ISC_F2_CK      = 4;

    // ****************************************
    // Check value helpers, most significant bit first
    // ****************************************
    function automatic logic [4:0] isc_crc_step(input logic [4:0] c, input logic b);
        return {c[3:0], 1'b0} ^ ((c[4] ^ b) ? ISC_CRC_POLY : 5'h00);
    endfunction

    function automatic logic [4:0] isc_crc5(input logic [18:0] d);
        logic [4:0] c;
        c = ISC_CRC_SEED;
        for (int i = ISC_CRC_SPAN - 1; i >= 0; i--)
        begin
            c = isc_crc_step(c, d[i]);
        end
        return c;
    endfunction

endpackage

//--- verilog/isc_spi_port.sv
// Serial port of the octal input serialiser with its command FIFO
`timescale 1ns/1ns

// ****************************************
// Command FIFO
// ****************************************
module isc_fifo
    import isc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule // isc_fifo

// ****************************************
// Serial port
// ****************************************
// Function
// - Check value uses generator x^5+x^4+x^2+1 in checked modes.
// - Check covers first 19 bits after seed 00111; appended as last five.
// - Failed check sets frame-check flag, gated onto fault; next good frame clears.
// - Commands in a frame failing its check are not executed.
// - Mode pins: 00/10 checked 24-bit, 01/11 unchecked 16-bit; high bit chains.
// - Chip select falling captures the eight inputs, disabled channels as zero, and opens the port.
// - Clock polarity and phase zero: sample on rise, shift on fall.
// - First bit in on SDI is the read/write selector.
// - Clock edges while chip select is high are ignored.
// - First eight SDO bits are captured inputs, highest channel first.
// - Direct modes answer a read in byte two; zeros after a write.
// - Chained modes decode at frame end; read data comes next frame.
// - Clock count not a multiple of eight discards data, sets count flag.
// - Port ignored, SDO released without core and logic supply; registers lost without core and field.
// - Power-up flag starts at one; writing zero to first fault register clears it.
// - Power-up: filters bypassed, channels enabled, only check and power-up flags enabled.
// - Bit 5 of first fault register summarises the second.
// - Reading a fault register clears its supply and count flags; persisting cause sets again.
// - Capture strobe freezes inputs across devices without shared chip select.
// - Input latches freeze on chip select or strobe; supply alarms on chip select.
// - Checked frames carry the two supply alarm bits before the check value.
// - Unchecked eight-clock frames return inputs and ignore the command.
module isc_spi_port
    import isc_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
)(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Serial link
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       sdi,
    output      logic       sdo,
    output      logic       sdo_oe_n,
    input  wire logic       capture_n,
    // Mode pins
    input  wire logic       check_disable_pin,
    input  wire logic       chain_select_pin,
    // Field side
    input  wire logic [7:0] field_inputs,
    input  wire logic       field_supply_low,
    input  wire logic       field_supply_missing,
    // Supply monitors
    input  wire logic       core_supply_ok,
    input  wire logic       logic_supply_ok,
    // Status pins
    output      logic       fault_o,
    output      logic       fault_oe_n,
    output      logic       ready_n,
    output      logic       cmd_ready
);
    // ****************************************
    // Synchronisers
    // ****************************************
    localparam int NS = 18;
    localparam int S_CS = 17, S_CK = 16, S_DI = 15, S_LT = 14, S_MD = 13, S_MC = 12;
    localparam int S_CO = 11, S_LO = 10, S_FL = 9, S_FM = 8;

    logic [NS-1:0] meta;
    logic [NS-1:0] sy;
    logic [NS-1:0] sy_d;
    wire  [NS-1:0] async_in = {cs_n, sclk, sdi, capture_n, check_disable_pin, chain_select_pin,
                               core_supply_ok, logic_supply_ok, field_supply_low,
                               field_supply_missing, field_inputs};

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            meta <= '0;
            sy   <= '0;
            sy_d <= '0;
        end
        else
        begin
            meta <= async_in;
            sy   <= meta;
            sy_d <= sy;
        end
    end

    // ****************************************
    // Decode of pins and link events
    // ****************************************
    logic        in_frame;
    logic [23:0] rx;
    logic [23:0] tx;
    logic [4:0]  rx_cnt;
    logic [2:0]  rx_mod;
    logic [4:0]  out_cnt;
    logic [4:0]  crc_tx;
    logic        rx_bit;
    logic [7:0]  din_latch;
    logic [1:0]  alarm_snap;
    logic        rd_pend;
    logic [7:0]  rd_hold;
    logic        crc_err;
    logic        por;
    logic        f_low;
    logic        f_miss;
    logic        ck_err;
    logic [7:0]  f1_en;
    logic [7:0]  f2_en;
    logic [7:0]  chan_en;
    logic [7:0]  flt [0:7];
    logic [7:0]  f1_val;
    logic [7:0]  f2_val;

    wire        checked    = ~sy[S_MD];
    wire        chained    = sy[S_MC];
    wire        port_en    = sy[S_CO] & sy[S_LO];
    wire        mem_lost   = ~sy[S_CO] & sy[S_FM];
    wire        regs_clr   = ~resetn | mem_lost;
    wire        cs_fall    = sy_d[S_CS] & ~sy[S_CS] & port_en & ~in_frame;
    wire        cs_rise    = in_frame & sy[S_CS];
    wire        sclk_rise  = in_frame & ~sy[S_CS] & ~sy_d[S_CK] & sy[S_CK];
    wire        sclk_fall  = in_frame & ~sy[S_CS] & sy_d[S_CK] & ~sy[S_CK];
    wire [4:0]  frame_len  = checked ? 5'(ISC_FRAME_CHK) : 5'(ISC_FRAME_RAW);
    wire        len_ok     = rx_mod == 3'h0;
    wire        cmd_ok     = len_ok & (rx_cnt >= frame_len);
    wire [15:0] cmd        = checked ? rx[23:8] : rx[15:0];
    wire        crc_bad    = checked & (isc_crc5(rx[23:5]) != rx[4:0]);
    wire        frame_exec = cs_rise & cmd_ok & ~crc_bad;
    wire        cmd_write  = cmd[15];
    wire [23:0] rx_next    = {rx[22:0], sy[S_DI]};
    wire        direct_rd  = sclk_rise & ~chained & (rx_cnt == 5'd7) & ~rx_next[7];

    // ****************************************
    // Register read decode
    // ****************************************
    wire [6:0]  rd_addr    = cs_rise ? cmd[14:8] : rx_next[6:0];
    wire        flt_hit    = (rd_addr >= ISC_A_FLT_BASE) & (rd_addr < ISC_A_FLT_END) & ~rd_addr[0];
    wire [6:0]  flt_off    = rd_addr - ISC_A_FLT_BASE;
    wire [7:0]  rd_data    = (rd_addr == ISC_A_INPUT)   ? din_latch :
                             (rd_addr == ISC_A_FAULT_STATUS_FIRST)  ? f1_val    :
                             (rd_addr == ISC_A_FAULT_STATUS_SECOND)  ? f2_val    :
                             (rd_addr == ISC_A_F1_EN)   ? f1_en     :
                             (rd_addr == ISC_A_F2_EN)   ? f2_en     :
                             (rd_addr == ISC_A_CHAN_EN) ? chan_en   :
                             flt_hit ? flt[flt_off[3:1]] : 8'h00;

    always_comb
    begin
        f2_val              = 8'h00;
        f2_val[ISC_F2_CK]   = ck_err;
        f1_val              = 8'h00;
        f1_val[ISC_F1_CRC]  = crc_err;
        f1_val[ISC_F1_POR]  = por;
        f1_val[ISC_F1_SUM]  = |f2_val;
        f1_val[ISC_F1_LOW]  = f_low;
        f1_val[ISC_F1_MISS] = f_miss;
    end

    // ****************************************
    // Command FIFO and executor
    // ****************************************
    // Draining only between frames keeps reads mid-frame consistent
    logic        ex_valid;
    logic [15:0] ex_cmd;
    wire         ex_go    = ex_valid & ~in_frame;
    wire         ex_wr    = ex_go & ex_cmd[15];
    wire         ex_rd    = ex_go & ~ex_cmd[15];
    wire [6:0]   ex_addr  = ex_cmd[14:8];
    wire [6:0]   ex_off   = ex_addr - ISC_A_FLT_BASE;
    wire         ex_flt   = ex_wr & (ex_addr >= ISC_A_FLT_BASE) & (ex_addr < ISC_A_FLT_END) & ~ex_addr[0];
    wire         rd_f1    = ex_rd & (ex_addr == ISC_A_FAULT_STATUS_FIRST);
    wire         rd_f2    = ex_rd & (ex_addr == ISC_A_FAULT_STATUS_SECOND);

    isc_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (~regs_clr),
        .in_valid  (frame_exec),
        .in_ready  (cmd_ready),
        .in_data   (cmd),
        .out_valid (ex_valid),
        .out_ready (~in_frame),
        .out_data  (ex_cmd)
    );

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (regs_clr)
        begin
            f1_en   <= ISC_RST_F1_EN;
            f2_en   <= ISC_RST_F2_EN;
            chan_en <= ISC_RST_CHAN;
            for (int i = 0; i < 8; i++)
                flt[i] <= ISC_RST_FLT;
        end
        else
        begin
            if (ex_wr & (ex_addr == ISC_A_F1_EN))
                f1_en <= ex_cmd[7:0];
            if (ex_wr & (ex_addr == ISC_A_F2_EN))
                f2_en <= ex_cmd[7:0];
            if (ex_wr & (ex_addr == ISC_A_CHAN_EN))
                chan_en <= ex_cmd[7:0];
            if (ex_flt)
                flt[ex_off[3:1]] <= ex_cmd[7:0];
        end
    end

    // ****************************************
    // Fault flags, set wins over clear
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (regs_clr)
        begin
            crc_err <= 1'b0;
            por     <= 1'b1;
            f_low   <= 1'b1;
            f_miss  <= 1'b1;
            ck_err  <= 1'b0;
        end
        else
        begin
            if (cs_rise & cmd_ok & checked)
                crc_err <= crc_bad;
            if (ex_wr & (ex_addr == ISC_A_FAULT_STATUS_FIRST) & ~ex_cmd[ISC_F1_POR])
                por <= 1'b0;
            f_low  <= sy[S_FL] | (f_low & ~rd_f1);
            f_miss <= sy[S_FM] | (f_miss & ~rd_f1);
            ck_err <= (cs_rise & ~len_ok) | (ck_err & ~rd_f2);
        end
    end

    // ****************************************
    // Input latches
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            din_latch  <= 8'h00;
            alarm_snap <= 2'b00;
        end
        else
        begin
            if (sy[S_CS] & sy[S_LT])
                din_latch <= sy[7:0] & chan_en;
            if (sy[S_CS])
                alarm_snap <= {f_low, f_miss};
        end
    end

    // ****************************************
    // Receive side
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            in_frame <= 1'b0;
            rx       <= 24'h000000;
            rx_cnt   <= 5'h00;
            rx_mod   <= 3'h0;
            rx_bit   <= 1'b0;
        end
        else if (cs_fall)
        begin
            in_frame <= 1'b1;
            rx_cnt   <= 5'h00;
            rx_mod   <= 3'h0;
        end
        else if (cs_rise | ~port_en)
            in_frame <= 1'b0;
        else if (sclk_rise)
        begin
            rx     <= rx_next;
            rx_bit <= sy[S_DI];
            rx_mod <= rx_mod + 3'h1;
            if (rx_cnt != 5'h1f)
                rx_cnt <= rx_cnt + 5'h01;
        end
    end

    // Chained read answered in the following frame
    always_ff @(posedge clk)
    begin
        if (regs_clr)
        begin
            rd_pend <= 1'b0;
            rd_hold <= 8'h00;
        end
        else if (frame_exec & chained)
        begin
            rd_pend <= ~cmd_write;
            rd_hold <= rd_data;
        end
    end

    // ****************************************
    // Transmit side
    // ****************************************
    // Tx doubles as the chain pass-through: received bits re-emerge one frame later
    wire [7:0]  byte2     = (chained & rd_pend) ? rd_hold : 8'h00;
    wire [23:0] tx_load   = checked ? {din_latch, byte2, alarm_snap, 1'b0, 5'h00}
                                    : {din_latch, byte2, 8'h00};
    wire [23:0] tx_shift  = checked ? {tx[22:0], rx_bit} : {tx[22:8], rx_bit, 8'h00};
    wire        crc_phase = checked & (out_cnt >= 5'(ISC_CRC_SPAN)) & (out_cnt < 5'(ISC_FRAME_CHK));

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tx      <= 24'h000000;
            out_cnt <= 5'h00;
            crc_tx  <= ISC_CRC_SEED;
        end
        else if (cs_fall)
        begin
            tx      <= tx_load;
            out_cnt <= 5'h00;
            crc_tx  <= ISC_CRC_SEED;
        end
        else if (direct_rd)
            tx[22:15] <= rd_data;
        else if (sclk_fall)
        begin
            tx <= tx_shift;
            if (out_cnt != 5'h1f)
                out_cnt <= out_cnt + 5'h01;
            if (out_cnt < 5'(ISC_CRC_SPAN))
                crc_tx <= isc_crc_step(crc_tx, tx[23]);
            else
                crc_tx <= {crc_tx[3:0], 1'b0};
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    wire fault_any = |(f1_val & f1_en) | |(f2_val & f2_en);

    assign fault_o = 1'b0;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sdo        <= 1'b0;
            sdo_oe_n   <= 1'b1;
            fault_oe_n <= 1'b1;
            ready_n    <= 1'b1;
        end
        else
        begin
            sdo        <= crc_phase ? crc_tx[4] : tx[23];
            sdo_oe_n   <= ~(in_frame & port_en);
            fault_oe_n <= ~fault_any;
            ready_n    <= ~port_en;
        end
    end
endmodule // isc_spi_port

//--- sim/isc_checker.sv
// Pin-level assertions for the serial port
`timescale 1ns/1ns

// ****************************************
// Checker
// ****************************************
module isc_checker
    import isc_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
)(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic sdo_oe_n,
    // Supplies and status
    input wire logic core_supply_ok,
    input wire logic logic_supply_ok,
    input wire logic fault_o,
    input wire logic fault_oe_n,
    input wire logic ready_n,
    input wire logic check_disable_pin,
    input wire logic chain_select_pin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Saturates so long idle spans never wrap
    logic [3:0] cs_idle;
    always_ff @(posedge clk)
    begin
        if (!resetn || !cs_n)
            cs_idle <= 4'h0;
        else if (cs_idle != 4'hf)
            cs_idle <= cs_idle + 4'h1;
    end

    a_idle_release: assert property (cs_idle >= 4'h8 |-> sdo_oe_n)
        else $error("sdo driven outside a frame");
    a_supply_release: assert property ((!core_supply_ok || !logic_supply_ok) [*6] |-> sdo_oe_n && ready_n)
        else $error("port active without supplies");
    a_ready_supplies: assert property ((core_supply_ok && logic_supply_ok) [*8] |-> !ready_n)
        else $error("ready missing with good supplies");
    a_frame_drive: assert property ($fell(cs_n) && !ready_n |-> ##[1:6] !sdo_oe_n)
        else $error("sdo not driven after select");
    a_frame_hold: assert property ((!cs_n && !ready_n) [*8] |-> !sdo_oe_n)
        else $error("sdo released inside a frame");
    a_sdo_steady: assert property (!ready_n && !cs_n && !$past(cs_n, 4) && sclk && $past(sclk, 3) |-> $stable(sdo))
        else $error("sdo moved while clock high");
    a_powerup_fault: assert property ($rose(resetn) |-> ##[2:8] !fault_oe_n)
        else $error("fault pin not asserted after reset");
    a_fault_drain: assert property (fault_o == 1'b0)
        else $error("fault pin drives high");

    c_chain: cover property ($fell(cs_n) && chain_select_pin);
    c_checked: cover property ($rose(cs_n) && !check_disable_pin);
    c_fault_idle: cover property (!fault_oe_n && cs_idle == 4'hf);
endmodule // isc_checker

bind isc_spi_port isc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clk(clk), .resetn(resetn), .cs_n(cs_n),
    .sclk(sclk), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .core_supply_ok(core_supply_ok), .logic_supply_ok(logic_supply_ok),
    .fault_o(fault_o), .fault_oe_n(fault_oe_n), .ready_n(ready_n), .check_disable_pin(check_disable_pin),
    .chain_select_pin(chain_select_pin));

//--- sim/isc_host.sv
// Host master model driving the serial link
`timescale 1ns/1ns

// ****************************************
// Host master
// ****************************************
module isc_host (
    // Clock
    input  wire logic clk,
    // Serial link
    output      logic cs_n,
    output      logic sclk,
    output      logic sdi,
    input  wire logic sdo
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end

    function automatic logic [4:0] crc5(input logic [18:0] d);
        logic [4:0] c;
        c = 5'h07;
        for (int i = 18; i >= 0; i--)
        begin
            c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? 5'h15 : 5'h00);
        end
        return c;
    endfunction

    // Sdo taken at end of high phase, well past the port's sync delay
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi <= tx[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            rx = {rx[30:0], sdo};
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        sdi  <= ~sdi;
        repeat (8) @(posedge clk);
    endtask
endmodule // isc_host

//--- sim/tb.sv
// Self-checking bench of the serial port
`timescale 1ns/1ns
`define CHK(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end \
    end

// ****************************************
// Bench
// ****************************************
module tb
    import isc_pkg::*;
;
    logic        clk, resetn, cs_n, sclk, sdi, sdo, sdo_line, sdo_oe_n, capture_n;
    logic        check_disable_pin, chain_select_pin, field_supply_low, field_supply_missing;
    logic        core_supply_ok, logic_supply_ok, fault_o, fault_oe_n, ready_n, cmd_ready;
    logic [7:0]  field_inputs, exp_in;
    logic [31:0] rx;
    int          errors, n_tests;

    // Released line shows the inverse so a stale bit cannot pass
    assign sdo_line = sdo_oe_n ? ~sdo : sdo;
    isc_spi_port #(.FIFO_DEPTH(16)) dut (.clk(clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n), .capture_n(capture_n), .check_disable_pin(check_disable_pin),
        .chain_select_pin(chain_select_pin), .field_inputs(field_inputs), .field_supply_low(field_supply_low),
        .field_supply_missing(field_supply_missing), .core_supply_ok(core_supply_ok),
        .logic_supply_ok(logic_supply_ok), .fault_o(fault_o), .fault_oe_n(fault_oe_n), .ready_n(ready_n),
        .cmd_ready(cmd_ready));
    isc_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d, input int n, input logic [4:0] bad);
        logic [18:0] f;
        f = {w, a, d, 3'b000};
        if (check_disable_pin)
            host.xfer(n, {16'h0, w, a, d} >> (16 - n), rx);
        else
            host.xfer(n, {8'h0, f, host.crc5(f) ^ bad} >> (24 - n), rx);
        `CHK(rx[n-1 -: 8], exp_in)
        if (!check_disable_pin && n == 24)
            `CHK(rx[4:0], host.crc5(rx[23:5]))
    endtask

    task automatic op(input logic w, input logic [6:0] a, input logic [7:0] d, input logic [7:0] exp);
        cmd(w, a, d, check_disable_pin ? 16 : 24, 5'h00);
        `CHK(check_disable_pin ? rx[7:0] : rx[15:8], exp)
    endtask

    task automatic t_powerup();
        `CHK(ready_n, 1'b0)
        `CHK(fault_oe_n, 1'b0)
        `CHK(cmd_ready, 1'b1)
        op(1'b0, ISC_A_FAULT_STATUS_FIRST, 8'h00, 8'h46);
        `CHK(rx[7:5], 3'b110)
        op(1'b0, ISC_A_CHAN_EN, 8'h00, 8'hff);
        op(1'b0, ISC_A_F1_EN, 8'h00, 8'hc0);
        op(1'b0, ISC_A_FLT_BASE, 8'h00, 8'h08);
        op(1'b0, ISC_A_FAULT_STATUS_FIRST, 8'h00, 8'h40);
        op(1'b1, ISC_A_FAULT_STATUS_FIRST, 8'h00, 8'h00);
        `CHK(fault_oe_n, 1'b1)
        cmd(1'b1, ISC_A_CHAN_EN, 8'h0f, 24, 5'h01);
        `CHK(fault_oe_n, 1'b0)
        op(1'b0, ISC_A_FAULT_STATUS_FIRST, 8'h00, 8'h80);
        op(1'b0, ISC_A_CHAN_EN, 8'h00, 8'hff);
        `CHK(fault_oe_n, 1'b1)
        $display("powerup and check done");
    endtask

    task automatic t_capture();
        field_inputs <= 8'h5a;
        repeat (4) @(posedge clk);
        capture_n    <= 1'b0;
        repeat (4) @(posedge clk);
        field_inputs <= 8'hc3;
        exp_in = 8'h5a;
        op(1'b0, ISC_A_F1_EN, 8'h00, 8'hc0);
        capture_n <= 1'b1;
        repeat (4) @(posedge clk);
        exp_in = 8'hc3;
        op(1'b0, ISC_A_F1_EN, 8'h00, 8'hc0);
        $display("capture done");
    endtask

    task automatic t_raw();
        check_disable_pin <= 1'b1;
        field_inputs      <= 8'h3c;
        exp_in = 8'h3c;
        repeat (4) @(posedge clk);
        cmd(1'b1, ISC_A_CHAN_EN, 8'h00, 8, 5'h00);
        cmd(1'b1, ISC_A_CHAN_EN, 8'h00, 12, 5'h00);
        op(1'b0, ISC_A_FAULT_STATUS_FIRST, 8'h00, 8'h20);
        op(1'b0, ISC_A_FAULT_STATUS_SECOND, 8'h00, 8'h10);
        op(1'b0, ISC_A_FAULT_STATUS_SECOND, 8'h00, 8'h00);
        op(1'b0, ISC_A_CHAN_EN, 8'h00, 8'hff);
        op(1'b1, ISC_A_CHAN_EN, 8'h3c, 8'h00);
        op(1'b0, ISC_A_CHAN_EN, 8'h00, 8'h3c);
        $display("unchecked direct done");
    endtask

    task automatic t_chain();
        for (int m = 0; m < 2; m++)
        begin
            check_disable_pin <= (m == 0);
            chain_select_pin  <= 1'b1;
            repeat (4) @(posedge clk);
            op(1'b0, ISC_A_F1_EN, 8'h00, m ? 8'hc0 : 8'h00);
            op(1'b0, ISC_A_CHAN_EN, 8'h00, 8'hc0);
            op(1'b1, ISC_A_F1_EN, 8'hc0, 8'h3c);
            op(1'b0, ISC_A_FAULT_STATUS_FIRST, 8'h00, 8'h00);
            if (m == 0)
            begin
                host.xfer(32, {16'h1234, 1'b0, ISC_A_F1_EN, 8'h00}, rx);
                `CHK(rx[15:0], 16'h1234)
            end
        end
        $display("chain done");
    endtask

    task automatic t_supply();
        check_disable_pin <= 1'b1;
        chain_select_pin  <= 1'b0;
        logic_supply_ok   <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK(ready_n, 1'b1)
        host.xfer(16, {16'h0, 1'b1, ISC_A_CHAN_EN, 8'hff}, rx);
        logic_supply_ok <= 1'b1;
        repeat (8) @(posedge clk);
        op(1'b0, ISC_A_CHAN_EN, 8'h00, 8'h3c);
        core_supply_ok <= 1'b0;
        repeat (8) @(posedge clk);
        core_supply_ok <= 1'b1;
        repeat (8) @(posedge clk);
        op(1'b0, ISC_A_CHAN_EN, 8'h00, 8'h3c);
        core_supply_ok       <= 1'b0;
        field_supply_missing <= 1'b1;
        repeat (8) @(posedge clk);
        core_supply_ok       <= 1'b1;
        field_supply_missing <= 1'b0;
        repeat (10) @(posedge clk);
        op(1'b0, ISC_A_CHAN_EN, 8'h00, 8'hff);
        `CHK(fault_oe_n, 1'b0)
        $display("supply done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #2000000;
        errors++;
        conclude();
    end

    initial
    begin
        errors = 0;
        n_tests = 0;
        resetn = 1'b0;
        capture_n = 1'b1;
        check_disable_pin = 1'b0;
        chain_select_pin = 1'b0;
        field_inputs = 8'ha5;
        exp_in = 8'ha5;
        field_supply_low = 1'b0;
        field_supply_missing = 1'b0;
        core_supply_ok = 1'b1;
        logic_supply_ok = 1'b1;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        t_powerup();
        t_capture();
        t_raw();
        t_chain();
        t_supply();
        conclude();
    end
endmodule // tb
